/* src/vrc_defs.svh */
// register offsets, field positions and reset values of the reference ladder control
`ifndef VRC_DEFS_SVH
`define VRC_DEFS_SVH
`define VRC_CTRL_OFFSET 16'h9800
`define VRC_ALIAS_CLR 4'h4
`define VRC_ALIAS_SET 4'h8
`define VRC_ALIAS_INV 4'hc
`define VRC_ENABLE_BIT 15
`define VRC_PIN_BIT 6
`define VRC_RANGE_BIT 5
`define VRC_SUPPLY_BIT 4
`define VRC_TAP_MSB 3
`define VRC_TAP_LSB 0
`define VRC_CTRL_RESET 32'h0000_0000
`define VRC_IMPL_MASK 32'h0000_807f
`define VRC_TAP_LEVELS 16
`endif

/* src/vrc_pkg.sv */
// types shared by the reference ladder control files
`default_nettype none
package vrc_pkg;
  typedef enum logic [1:0] {
    VRC_OP_WRITE,
    VRC_OP_CLR,
    VRC_OP_SET,
    VRC_OP_INV
  } vrc_op_t;

  // analog-facing control bundle
  typedef struct packed {
    logic enable;
    logic pin_drive;
    logic low_range;
    logic ext_supply;
    logic [3:0] tap_code;
  } vrc_analog_t;
endpackage : vrc_pkg
`default_nettype wire

/* src/vrc_alias_update.sv */
// bitwise write, clear, set and invert update of one register word
`default_nettype none
module vrc_alias_update #(
  parameter int WIDTH = 32
) (
  // operands
  input wire logic [WIDTH-1:0] current_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [WIDTH-1:0] mask_i,
  input wire vrc_pkg::vrc_op_t op_i,
  // result
  output logic [WIDTH-1:0] result_o
);
  logic [WIDTH-1:0] raw;

  always_comb begin
    case (op_i)
      vrc_pkg::VRC_OP_WRITE: raw = data_i;
      vrc_pkg::VRC_OP_CLR: raw = current_i & ~data_i;
      vrc_pkg::VRC_OP_SET: raw = current_i | data_i;
      vrc_pkg::VRC_OP_INV: raw = current_i ^ data_i;
      default: raw = current_i;
    endcase
  end

  // unimplemented bits are forced to zero in the result
  assign result_o = raw & mask_i;
endmodule : vrc_alias_update
`default_nettype wire

/* src/vrc_top.sv */
// reference ladder control: avalon-mm slave, control register and analog controls
//
// Local design decision: the Avalon-MM register port.
`include "vrc_defs.svh"
`default_nettype none
module vrc_top #(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // analog ladder controls
  output logic ladder_power_down_o,
  output logic ladder_pin_drive_enable_o,
  output logic ladder_range_select_o,
  output logic ladder_supply_select_o,
  output logic [3:0] ladder_tap_code_o,
  output logic [3:0] ladder_effective_tap_o,
  output vrc_pkg::vrc_analog_t comparator_ref_o
);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [31:0] reference_ladder_control;
  logic [31:0] next_reference_ladder_control;
  logic [31:0] be_mask;
  logic hit;
  logic [3:0] sub;
  logic done;
  vrc_pkg::vrc_op_t op;

  assign sub = avs_address_i[3:0];
  assign hit = (avs_address_i[ADDR_W-1:4] == (ADDR_W-4)'(`VRC_CTRL_OFFSET >> 4))
               && (sub[1:0] == 2'b00);
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    case (sub)
      `VRC_ALIAS_CLR: op = vrc_pkg::VRC_OP_CLR;
      `VRC_ALIAS_SET: op = vrc_pkg::VRC_OP_SET;
      `VRC_ALIAS_INV: op = vrc_pkg::VRC_OP_INV;
      default: op = vrc_pkg::VRC_OP_WRITE;
    endcase
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait cycle per access: answer registered, easy timing
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done <= 1'b0;
    end else begin
      done <= (avs_read_i || avs_write_i) && !done;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !done;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // byte lanes not enabled keep their bits: merge them back in
  logic [31:0] masked_data;
  always_comb begin
    if (op == vrc_pkg::VRC_OP_WRITE) begin
      masked_data = (avs_writedata_i & be_mask) | (reference_ladder_control & ~be_mask);
    end else begin
      masked_data = avs_writedata_i & be_mask;
    end
  end

  vrc_alias_update #(
    .WIDTH(32)
  ) u_alias (
    .current_i(reference_ladder_control),
    .data_i(masked_data),
    .mask_i(`VRC_IMPL_MASK),
    .op_i(op),
    .result_o(next_reference_ladder_control)
  );

  // set and clear aliases touch only the written bits, so changing the enable through them never disturbs others
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reference_ladder_control <= `VRC_CTRL_RESET;
    end else if (avs_write_i && done && hit) begin
      reference_ladder_control <= next_reference_ladder_control;
    end
  end

  // read data registered at the answering edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else if ((avs_read_i || avs_write_i) && !done) begin
      // all aliases read back the control word
      avs_readdata_o <= (hit && avs_read_i) ?
                        (reference_ladder_control & `VRC_IMPL_MASK) : 32'h0000_0000;
      avs_response_o <= hit ? 2'h0 : 2'h2;
    end
  end

  // ----------------------------------------------------------------
  // analog controls
  // ----------------------------------------------------------------
  logic enable;
  assign enable = reference_ladder_control[`VRC_ENABLE_BIT];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ladder_power_down_o <= 1'b1;
      ladder_pin_drive_enable_o <= 1'b0;
      ladder_range_select_o <= 1'b0;
      ladder_supply_select_o <= 1'b0;
      ladder_tap_code_o <= 4'h0;
    end else begin
      ladder_power_down_o <= !enable;
      ladder_pin_drive_enable_o <= reference_ladder_control[`VRC_PIN_BIT];
      ladder_range_select_o <= reference_ladder_control[`VRC_RANGE_BIT];
      ladder_supply_select_o <= reference_ladder_control[`VRC_SUPPLY_BIT];
      ladder_tap_code_o <= reference_ladder_control[`VRC_TAP_MSB:`VRC_TAP_LSB];
    end
  end

  // tap handed to the ladder decoder; a powered-down ladder reports
  // zero so no tap is selected while it draws no current
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ladder_effective_tap_o <= 4'h0;
      comparator_ref_o <= '0;
    end else begin
      ladder_effective_tap_o <= enable ?
        reference_ladder_control[`VRC_TAP_MSB:`VRC_TAP_LSB] : 4'h0;
      comparator_ref_o.enable <= enable;
      comparator_ref_o.pin_drive <= reference_ladder_control[`VRC_PIN_BIT];
      comparator_ref_o.low_range <= reference_ladder_control[`VRC_RANGE_BIT];
      comparator_ref_o.ext_supply <= reference_ladder_control[`VRC_SUPPLY_BIT];
      comparator_ref_o.tap_code <= reference_ladder_control[`VRC_TAP_MSB:`VRC_TAP_LSB];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_power_follows_enable;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 (ladder_power_down_o == !$past(reference_ladder_control[15]));
  endproperty
  a_power_follows_enable: assert property (p_power_follows_enable)
    else $error("power down does not follow enable");

  property p_enable_keeps_others;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && done && hit
       && (op == vrc_pkg::VRC_OP_SET || op == vrc_pkg::VRC_OP_CLR)
       && masked_data == 32'h0000_8000) |=> (reference_ladder_control[6:0]
       == $past(reference_ladder_control[6:0]));
  endproperty
  a_enable_keeps_others: assert property (p_enable_keeps_others)
    else $error("setting enable changed another field");

  property p_pin_drive;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 (ladder_pin_drive_enable_o == $past(reference_ladder_control[6]));
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("pin drive mismatch");

  property p_range_supply;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 (ladder_range_select_o == $past(reference_ladder_control[5])
           && ladder_supply_select_o == $past(reference_ladder_control[4]));
  endproperty
  a_range_supply: assert property (p_range_supply)
    else $error("range or supply select mismatch");

  property p_tap_code;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 (ladder_tap_code_o == $past(reference_ladder_control[3:0])
           && comparator_ref_o.tap_code == ladder_tap_code_o);
  endproperty
  a_tap_code: assert property (p_tap_code)
    else $error("tap code mismatch");

  property p_unimpl_zero;
    @(posedge clock_i) disable iff (!rst_n_i)
      (reference_ladder_control & ~`VRC_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit set");

  property p_set_alias;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && done && hit && op == vrc_pkg::VRC_OP_SET)
      |=> ((reference_ladder_control & $past(masked_data) & `VRC_IMPL_MASK)
           == ($past(masked_data) & `VRC_IMPL_MASK));
  endproperty
  a_set_alias: assert property (p_set_alias)
    else $error("set alias failed");

  property p_clr_alias;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && done && hit && op == vrc_pkg::VRC_OP_CLR)
      |=> ((reference_ladder_control & $past(masked_data)) == 32'h0000_0000);
  endproperty
  a_clr_alias: assert property (p_clr_alias)
    else $error("clear alias failed");

  property p_wait_one;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("read not answered after one wait cycle");

  property p_inv_alias;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && done && hit && op == vrc_pkg::VRC_OP_INV)
      |=> (reference_ladder_control
           == (($past(reference_ladder_control) ^ $past(masked_data)) & `VRC_IMPL_MASK));
  endproperty
  a_inv_alias: assert property (p_inv_alias)
    else $error("invert alias failed");

  property p_plain_write;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && done && hit && op == vrc_pkg::VRC_OP_WRITE)
      |=> (reference_ladder_control == ($past(masked_data) & `VRC_IMPL_MASK));
  endproperty
  a_plain_write: assert property (p_plain_write)
    else $error("plain write stored a wrong word");

  // only a completed write to a mapped address may touch the word
  property p_word_holds;
    @(posedge clock_i) disable iff (!rst_n_i)
      !(avs_write_i && done && hit) |=> $stable(reference_ladder_control);
  endproperty
  a_word_holds: assert property (p_word_holds)
    else $error("control word changed without a mapped write");

  property p_read_data;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_read_i && !done && hit)
      |=> (avs_readdata_o == ($past(reference_ladder_control) & `VRC_IMPL_MASK));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differs from the control word");

  property p_unmapped_answer;
    @(posedge clock_i) disable iff (!rst_n_i)
      ((avs_read_i || avs_write_i) && !done && !hit)
      |=> (avs_response_o == 2'h2 && avs_readdata_o == 32'h0000_0000);
  endproperty
  a_unmapped_answer: assert property (p_unmapped_answer)
    else $error("unmapped access not refused");

  property p_mapped_answer;
    @(posedge clock_i) disable iff (!rst_n_i)
      ((avs_read_i || avs_write_i) && !done && hit) |=> (avs_response_o == 2'h0);
  endproperty
  a_mapped_answer: assert property (p_mapped_answer)
    else $error("mapped access answered with an error");

  property p_wait_write;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait_write: assert property (p_wait_write)
    else $error("write not answered after one wait cycle");

  property p_supply_select;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 (ladder_supply_select_o == $past(reference_ladder_control[`VRC_SUPPLY_BIT])
           && comparator_ref_o.ext_supply == ladder_supply_select_o);
  endproperty
  a_supply_select: assert property (p_supply_select)
    else $error("supply select mismatch");

  // the comparator bundle must agree with the pin-side copies
  property p_comparator_route;
    @(posedge clock_i) disable iff (!rst_n_i)
      comparator_ref_o == {!ladder_power_down_o, ladder_pin_drive_enable_o,
                           ladder_range_select_o, ladder_supply_select_o, ladder_tap_code_o};
  endproperty
  a_comparator_route: assert property (p_comparator_route)
    else $error("comparator bundle differs from the ladder controls");

  property p_effective_tap;
    @(posedge clock_i) disable iff (!rst_n_i)
      ##1 (ladder_effective_tap_o == ($past(reference_ladder_control[`VRC_ENABLE_BIT])
           ? $past(reference_ladder_control[`VRC_TAP_MSB:`VRC_TAP_LSB]) : 4'h0));
  endproperty
  a_effective_tap: assert property (p_effective_tap)
    else $error("effective tap mismatch");

  property p_clear_powers_down;
    @(posedge clock_i) disable iff (!rst_n_i)
      (avs_write_i && done && hit && op == vrc_pkg::VRC_OP_CLR
       && masked_data[`VRC_ENABLE_BIT]) |=> ##1 ladder_power_down_o;
  endproperty
  a_clear_powers_down: assert property (p_clear_powers_down)
    else $error("clearing enable did not power the ladder down");

  // no disable here: values seen just after release must be the reset ones
  property p_reset_state;
    @(posedge clock_i)
      $rose(rst_n_i) |-> (reference_ladder_control == `VRC_CTRL_RESET
        && ladder_power_down_o && !ladder_pin_drive_enable_o && !ladder_range_select_o
        && !ladder_supply_select_o && ladder_tap_code_o == 4'h0
        && ladder_effective_tap_o == 4'h0 && comparator_ref_o == '0);
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset is not the reset state");

  c_enable: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(ladder_power_down_o));
  c_inv: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    avs_write_i && done && hit && op == vrc_pkg::VRC_OP_INV);
  c_read: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    avs_read_i && done && hit);
  c_unmapped: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && done && !hit);
endmodule : vrc_top
`default_nettype wire

/* sim/vrc_top_tb.sv */
// self-checking bench for the reference ladder control block
`include "vrc_defs.svh"
`default_nettype none
module vrc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // design ports and bench state
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] avs_address_i = 16'h0000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic pd, pin, rng, sup;
  logic [3:0] tap, eff;
  vrc_pkg::vrc_analog_t cref;
  int miscompares = 0;
  int total_checks = 0;
  logic [31:0] model = `VRC_CTRL_RESET;
  logic [31:0] rd;
  logic [1:0] rs;
  int i;
  logic [15:0] ua;

  vrc_top u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .ladder_power_down_o(pd),
    .ladder_pin_drive_enable_o(pin), .ladder_range_select_o(rng),
    .ladder_supply_select_o(sup), .ladder_tap_code_o(tap),
    .ladder_effective_tap_o(eff), .comparator_ref_o(cref)
  );

  initial forever #20 clock_i = ~clock_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  function automatic logic mapped(input logic [15:0] a);
    return a == 16'h9800 || a == 16'h9804 || a == 16'h9808 || a == 16'h980c;
  endfunction

  // leading edge keeps a spare cycle after every access, e.g. after enable clear
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) cmp("waitrequest", 32'h0, 32'h1);
    rd = avs_readdata_o;
    rs = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1'b1, a, wd, be);
    case (a)
      16'h9800: model = (model & ~m) | (wd & m);
      16'h9804: model = model & ~(wd & m);
      16'h9808: model = model | (wd & m);
      16'h980c: model = model ^ (wd & m);
      default: ;
    endcase
    model = model & `VRC_IMPL_MASK;
    cmp("write response", {30'h0, mapped(a) ? 2'b00 : 2'b10}, {30'h0, rs});
  endtask

  task automatic rd_chk(input logic [15:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    cmp("readdata", mapped(a) ? model : 32'h0000_0000, rd);
    cmp("read response", {30'h0, mapped(a) ? 2'b00 : 2'b10}, {30'h0, rs});
  endtask

  task automatic out_chk();
    logic [7:0] f;
    logic [31:0] e;
    logic [31:0] g;
    @(posedge clock_i);
    #1;
    f = {model[15], model[6], model[5], model[4], model[3:0]};
    e = {12'h0, !f[7], f[6:0], f[7] ? f[3:0] : 4'h0, f};
    g = {12'h0, pd, pin, rng, sup, tap, eff, cref};
    cmp("ladder outputs", e, g);
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h306b));
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    out_chk();
    rd_chk(16'h9800);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      wr(16'h9800, ($urandom() | 32'hffff_7f80) & 32'hffff_fff0 | i, 4'hf);
      out_chk();
      rd_chk(16'h9800);
    end
    $display("test plain writes done");
    for (i = 0; i < 32; i++) begin
      wr(16'h9800 + 16'(4 * ($urandom() % 4)), $urandom(), 4'($urandom()));
      out_chk();
      rd_chk(16'h9800 + 16'(4 * (i % 4)));
    end
    $display("test alias writes done");
    wr(16'h9800, 32'h0000_005a, 4'hf);
    for (i = 0; i < 4; i++) begin
      wr(i[0] ? 16'h9804 : 16'h9808, 32'h0000_8000, 4'hf);
      out_chk();
      rd_chk(16'h9800);
    end
    $display("test enable toggle done");
    for (i = 0; i < 4; i++) begin
      ua = i == 0 ? 16'h9801 : i == 1 ? 16'h9810 : i == 2 ? 16'h0000 : 16'h980e;
      wr(ua, '1, 4'hf);
      rd_chk(i == 0 ? 16'h9803 : 16'h9814);
      rd_chk(16'h9800);
    end
    $display("test unmapped done");
    wr(16'h9800, 32'h0000_807f, 4'hf);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    model = `VRC_CTRL_RESET;
    out_chk();
    rd_chk(16'h9800);
    $display("test mid-run reset done");
    results();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (6000) @(posedge clock_i);
    miscompares++;
    results();
  end
endmodule // vrc_top_tb
`default_nettype wire
